// ==== rtl/pdc_pkg.sv ====
`default_nettype none

package pdc_pkg;

	// Register byte offsets of the pad configuration bank.
	localparam logic [7:0] ROW_PIN_DRIVE_STRENGTH_OFS = 8'ha0;
	localparam logic [7:0] COLUMN_PIN_DRIVE_STRENGTH_OFS = 8'ha2;
	localparam logic [7:0] MISC_PIN_DRIVE_STRENGTH_OFS = 8'ha4;
	localparam logic [7:0] HOST_PIN_DRIVE_STRENGTH_OFS = 8'ha6;
	localparam logic [7:0] DIRECT_KEY_PULL_SELECT_OFS = 8'ha8;
	localparam logic [7:0] ROW_PIN_PULL_SELECT_OFS = 8'haa;
	localparam logic [7:0] COLUMN_PIN_PULL_SELECT_OFS = 8'hac;
	localparam logic [7:0] MISC_PIN_PULL_SELECT_OFS = 8'hae;
	localparam logic [7:0] HIGH_BYTE_STEP = 8'h01;

	// Pins: row 0-7, column 0-11, pulse 0-2, extra I/O, then two more per kind.
	localparam int PIN_COUNT = 26;
	localparam int FIELD_BITS = 2 * PIN_COUNT;

	// Reset values.
	localparam logic [15:0] PULL_WIDE_RESET = 16'haaaa;
	localparam logic [3:0] PULL_NARROW_RESET = 4'ha;
	localparam logic [15:0] DRIVE_WIDE_RESET = 16'h0000;
	localparam logic [3:0] DRIVE_NARROW_RESET = 4'h0;

	// Field encodings.
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] DRIVE_SEL_WEAK = 2'h0;
	localparam logic [1:0] DRIVE_SEL_STRONG = 2'h3;

	// Decoded drive levels on the pad control outputs.
	localparam logic [1:0] LEVEL_WEAK = 2'h0;
	localparam logic [1:0] LEVEL_MEDIUM = 2'h1;
	localparam logic [1:0] LEVEL_STRONG = 2'h2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic stop;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pdc_req_type;

	typedef struct packed {
		logic [15:0] drv_row;
		logic [15:0] drv_col;
		logic [15:0] drv_misc;
		logic [3:0] drv_host;
		logic [3:0] pull_ext;
		logic [15:0] pull_row;
		logic [15:0] pull_col;
		logic [15:0] pull_misc;
		logic pend_valid;
		logic [7:0] pend_addr;
		logic [7:0] pend_byte;
		logic [7:0] rdata;
		logic rvalid;
		logic [PIN_COUNT-1:0] pull_up;
		logic [PIN_COUNT-1:0] pull_down;
		logic [FIELD_BITS-1:0] drive_level;
	} pdc_state_type;

	function automatic logic pull_up_of(input logic [1:0] sel);
		return sel[1];
	endfunction

	function automatic logic pull_down_of(input logic [1:0] sel);
		return sel == PULL_DOWN;
	endfunction

	function automatic logic [1:0] drive_level_of(input logic [1:0] sel);
		logic [1:0] lvl;
		lvl = LEVEL_MEDIUM;
		if (sel == DRIVE_SEL_WEAK)
			lvl = LEVEL_WEAK;
		else if (sel == DRIVE_SEL_STRONG)
			lvl = LEVEL_STRONG;
		return lvl;
	endfunction

	function automatic logic is_wide_base(input logic [7:0] addr);
		return addr == ROW_PIN_DRIVE_STRENGTH_OFS || addr == COLUMN_PIN_DRIVE_STRENGTH_OFS
			|| addr == MISC_PIN_DRIVE_STRENGTH_OFS || addr == ROW_PIN_PULL_SELECT_OFS
			|| addr == COLUMN_PIN_PULL_SELECT_OFS || addr == MISC_PIN_PULL_SELECT_OFS;
	endfunction

endpackage

`default_nettype wire

// ==== rtl/pdc_pad_decode.sv ====
`timescale 1ns/1ps
`default_nettype none

module pdc_pad_decode #(
	parameter int PINS = 26
) (
	// Programmed fields, two bits per pin, and pin direction, one bit per pin.
	input wire logic [2*PINS-1:0] pull_sel,
	input wire logic [2*PINS-1:0] drive_sel,
	input wire logic [PINS-1:0] out_en,
	// Decoded pad controls.
	output logic [PINS-1:0] pull_up,
	output logic [PINS-1:0] pull_down,
	output logic [2*PINS-1:0] drive_level
);

	always_comb
	begin
		for (int i = 0; i < PINS; i++)
		begin
			// A driving pin never fights its own resistor. [RL2]
			pull_up[i] = pdc_pkg::pull_up_of(pull_sel[2*i +: 2]) && !out_en[i]; // [RL1] [RL17]
			pull_down[i] = pdc_pkg::pull_down_of(pull_sel[2*i +: 2]) && !out_en[i]; // [RL1] [RL17]
			drive_level[2*i +: 2] = pdc_pkg::drive_level_of(drive_sel[2*i +: 2]); // [RL9] [RL17]
		end
	end

endmodule

`default_nettype wire

// ==== rtl/pdc_pad_config.sv ====
// Function
// [RL1] Pull select 00 none, 01 down, 10/11 up; never both directions.
// [RL2] Pulls off while the pin drives as output, restored on input.
// [RL3] Software should give floating pins a nonzero pull select.
// [RL4] After reset every pull field reads 10, pull-up.
// [RL5] Row pull register 0xaa: row pin n at bits 2n+1:2n.
// [RL6] Column pull register 0xac: column pin n at bits 2n+1:2n.
// [RL7] Pull 0xae: columns 8-11 bits 7:0, pulse 13:8, extra 15:14.
// [RL8] Pull 0xa8: direct key a bits 1:0, b 3:2, 7:4 read zero.
// [RL9] Drive select 00 weakest, 01/10 medium, 11 strongest.
// [RL10] After reset every drive field reads 00.
// [RL11] Row drive register 0xa0: row pin n at bits 2n+1:2n.
// [RL12] Column drive register 0xa2: column pin n at bits 2n+1:2n.
// [RL13] Drive 0xa4: columns 8-11 bits 7:0, pulse 13:8, extra 15:14.
// [RL14] Drive 0xa6: interrupt pin drive in bits 3:2, upper bits unused.
// [RL15] Drive 0xa6: serial data line drive in bits 1:0.
// [RL16] Two-byte write aborted after first byte leaves register unchanged.
// [RL17] Per-pin gated pull-up, gated pull-down and drive level, registered with the fields.
`timescale 1ns/1ps
`default_nettype none

module pdc_pad_config (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	// Byte register access from the host serial slave.
	input wire pdc_pkg::pdc_req_type req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Pin direction from the pin multiplexer.
	input wire logic [pdc_pkg::PIN_COUNT-1:0] pin_out_en,
	// Pad controls.
	output logic [pdc_pkg::PIN_COUNT-1:0] pull_up_en,
	output logic [pdc_pkg::PIN_COUNT-1:0] pull_down_en,
	output logic [pdc_pkg::FIELD_BITS-1:0] drive_level
);

	pdc_pkg::pdc_state_type st_reg;
	pdc_pkg::pdc_state_type st_next;
	logic [pdc_pkg::FIELD_BITS-1:0] pull_all;
	logic [pdc_pkg::FIELD_BITS-1:0] drive_all;
	logic [pdc_pkg::PIN_COUNT-1:0] dec_up;
	logic [pdc_pkg::PIN_COUNT-1:0] dec_down;
	logic [pdc_pkg::FIELD_BITS-1:0] dec_level;
	logic [15:0] commit_word;
	logic commit_ok;

	// Decoding from the next fields puts a write and its pad effect on one edge.
	assign pull_all = {st_next.pull_ext, st_next.pull_misc, st_next.pull_col,
		st_next.pull_row}; // [RL5] [RL6] [RL7] [RL8]
	assign drive_all = {st_next.drv_host, st_next.drv_misc, st_next.drv_col,
		st_next.drv_row}; // [RL11] [RL12] [RL13] [RL14] [RL15]
	assign commit_word = {req.wdata, st_reg.pend_byte};
	assign commit_ok = st_reg.pend_valid && st_reg.pend_addr == req.addr - pdc_pkg::HIGH_BYTE_STEP;

	pdc_pad_decode #(
		.PINS(pdc_pkg::PIN_COUNT)
	) u_decode (
		.pull_sel(pull_all),
		.drive_sel(drive_all),
		.out_en(pin_out_en),
		.pull_up(dec_up),
		.pull_down(dec_down),
		.drive_level(dec_level)
	);

	function automatic logic [7:0] read_byte(input pdc_pkg::pdc_state_type s,
		input logic [7:0] addr);
		logic [7:0] d;
		d = 8'h00;
		unique case (addr)
			pdc_pkg::ROW_PIN_DRIVE_STRENGTH_OFS: d = s.drv_row[7:0];
			pdc_pkg::ROW_PIN_DRIVE_STRENGTH_OFS + 8'h01: d = s.drv_row[15:8];
			pdc_pkg::COLUMN_PIN_DRIVE_STRENGTH_OFS: d = s.drv_col[7:0];
			pdc_pkg::COLUMN_PIN_DRIVE_STRENGTH_OFS + 8'h01: d = s.drv_col[15:8];
			pdc_pkg::MISC_PIN_DRIVE_STRENGTH_OFS: d = s.drv_misc[7:0];
			pdc_pkg::MISC_PIN_DRIVE_STRENGTH_OFS + 8'h01: d = s.drv_misc[15:8];
			pdc_pkg::HOST_PIN_DRIVE_STRENGTH_OFS: d = {4'h0, s.drv_host};
			pdc_pkg::DIRECT_KEY_PULL_SELECT_OFS: d = {4'h0, s.pull_ext}; // [RL8]
			pdc_pkg::ROW_PIN_PULL_SELECT_OFS: d = s.pull_row[7:0];
			pdc_pkg::ROW_PIN_PULL_SELECT_OFS + 8'h01: d = s.pull_row[15:8];
			pdc_pkg::COLUMN_PIN_PULL_SELECT_OFS: d = s.pull_col[7:0];
			pdc_pkg::COLUMN_PIN_PULL_SELECT_OFS + 8'h01: d = s.pull_col[15:8];
			pdc_pkg::MISC_PIN_PULL_SELECT_OFS: d = s.pull_misc[7:0];
			pdc_pkg::MISC_PIN_PULL_SELECT_OFS + 8'h01: d = s.pull_misc[15:8];
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	always_comb
	begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		if (req.rd)
		begin
			st_next.rdata = read_byte(st_reg, req.addr);
			st_next.rvalid = 1'b1;
		end
		if (req.wr)
		begin
			// Any byte other than the matching high byte cancels a held low byte.
			st_next.pend_valid = 1'b0;
			if (pdc_pkg::is_wide_base(req.addr))
			begin
				st_next.pend_valid = 1'b1;
				st_next.pend_addr = req.addr;
				st_next.pend_byte = req.wdata;
			end
			else if (req.addr == pdc_pkg::HOST_PIN_DRIVE_STRENGTH_OFS)
				st_next.drv_host = req.wdata[3:0]; // [RL14] [RL15]
			else if (req.addr == pdc_pkg::DIRECT_KEY_PULL_SELECT_OFS)
				st_next.pull_ext = req.wdata[3:0]; // [RL8]
			else if (commit_ok)
			begin
				unique case (st_reg.pend_addr)
					pdc_pkg::ROW_PIN_DRIVE_STRENGTH_OFS: st_next.drv_row = commit_word; // [RL11]
					pdc_pkg::COLUMN_PIN_DRIVE_STRENGTH_OFS: st_next.drv_col = commit_word; // [RL12]
					pdc_pkg::MISC_PIN_DRIVE_STRENGTH_OFS: st_next.drv_misc = commit_word; // [RL13]
					pdc_pkg::ROW_PIN_PULL_SELECT_OFS: st_next.pull_row = commit_word; // [RL5]
					pdc_pkg::COLUMN_PIN_PULL_SELECT_OFS: st_next.pull_col = commit_word; // [RL6]
					pdc_pkg::MISC_PIN_PULL_SELECT_OFS: st_next.pull_misc = commit_word; // [RL7]
					default: st_next.pend_valid = 1'b0;
				endcase
			end
		end
		// A transfer that ends after the low byte drops it unused. [RL16]
		if (req.stop)
			st_next.pend_valid = 1'b0;
		st_next.pull_up = dec_up; // [RL17]
		st_next.pull_down = dec_down; // [RL17]
		st_next.drive_level = dec_level; // [RL17]
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_reg <= '0;
			st_reg.pull_row <= pdc_pkg::PULL_WIDE_RESET; // [RL4]
			st_reg.pull_col <= pdc_pkg::PULL_WIDE_RESET; // [RL4]
			st_reg.pull_misc <= pdc_pkg::PULL_WIDE_RESET; // [RL4]
			st_reg.pull_ext <= pdc_pkg::PULL_NARROW_RESET; // [RL4]
			st_reg.drv_row <= pdc_pkg::DRIVE_WIDE_RESET; // [RL10]
			st_reg.drv_col <= pdc_pkg::DRIVE_WIDE_RESET; // [RL10]
			st_reg.drv_misc <= pdc_pkg::DRIVE_WIDE_RESET; // [RL10]
			st_reg.drv_host <= pdc_pkg::DRIVE_NARROW_RESET; // [RL10]
			st_reg.pull_up <= '1;
		end
		else if (ce)
			st_reg <= st_next;
	end

	assign reg_rdata = st_reg.rdata;
	assign reg_rvalid = st_reg.rvalid;
	assign pull_up_en = st_reg.pull_up;
	assign pull_down_en = st_reg.pull_down;
	assign drive_level = st_reg.drive_level;

	// Checks.
	logic seen_edge_reg;
	logic [pdc_pkg::PIN_COUNT-1:0] level_strong;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			seen_edge_reg <= 1'b0;
		else if (ce)
			seen_edge_reg <= 1'b1;
	end

	always_comb
	begin
		for (int i = 0; i < pdc_pkg::PIN_COUNT; i++)
			level_strong[i] = drive_level[2*i +: 2] == pdc_pkg::LEVEL_STRONG;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	AST_PULL_EXCLUSIVE: assert property ((pull_up_en & pull_down_en) == '0) // [RL1]
		else $error("Pull-up and pull-down enabled together.");
	AST_PULL_OFF_OUTPUT: assert property (ce |=> ((pull_up_en | pull_down_en)
		& $past(pin_out_en)) == '0) // [RL2]
		else $error("Pull resistor active on a driving pin.");
	AST_PULL_RESET: assert property (!seen_edge_reg |-> st_reg.pull_row == 16'haaaa
		&& st_reg.pull_col == 16'haaaa && st_reg.pull_misc == 16'haaaa
		&& st_reg.pull_ext == 4'ha && pull_up_en == '1) // [RL4]
		else $error("Pull fields not at pull-up after reset.");
	AST_DRIVE_RESET: assert property (!seen_edge_reg |-> drive_level == '0
		&& st_reg.drv_host == 4'h0 && st_reg.drv_row == 16'h0000) // [RL10]
		else $error("Drive fields not weakest after reset.");
	AST_ROW_PULL_COMMIT: assert property (ce && req.wr && req.addr == 8'hab
		&& st_reg.pend_valid && st_reg.pend_addr == 8'haa
		|=> st_reg.pull_row == {$past(req.wdata), $past(st_reg.pend_byte)}) // [RL5]
		else $error("Row pull register did not take the two-byte write.");
	AST_COL_PULL_PIN: assert property (ce && req.wr && req.addr == 8'had
		&& st_reg.pend_valid && st_reg.pend_addr == 8'hac && req.wdata[7:6] == 2'h1
		&& !pin_out_en[15] |=> pull_down_en[15] && !pull_up_en[15]) // [RL6]
		else $error("Column pin 7 pull-down not at bits 15:14.");
	AST_MISC_DRIVE_PIN: assert property (ce && req.wr && req.addr == 8'ha5
		&& st_reg.pend_valid && st_reg.pend_addr == 8'ha4 && req.wdata[7:6] == 2'h3
		|=> level_strong[23]) // [RL9] [RL13]
		else $error("Extra pin drive not strongest after select 11.");
	// A high byte that follows a stop must find no low byte left to pair with.
	AST_ABORT_KEEPS: assert property (ce && req.stop && !req.wr ##1 ce && req.wr
		&& req.addr == 8'hab
		|=> $stable(st_reg.pull_row) && !st_reg.pend_valid) // [RL16]
		else $error("Aborted two-byte write changed a register.");
	AST_HOST_DRIVE: assert property (ce && req.wr && req.addr == 8'ha6
		|=> st_reg.drv_host == $past(req.wdata[3:0])
		&& drive_level[51:50] == pdc_pkg::drive_level_of($past(req.wdata[3:2]))) // [RL14] [RL15]
		else $error("Host pin drive register write not applied.");
	AST_EXT_READ_ZERO: assert property (ce && req.rd && req.addr == 8'ha8
		|=> reg_rvalid && reg_rdata[7:4] == 4'h0
		&& reg_rdata[3:0] == $past(st_reg.pull_ext)) // [RL8]
		else $error("Direct key pull register read wrong.");

	COV_WIDE_COMMIT: cover property (ce && req.wr && commit_ok ##1 ce && req.rd);
	COV_ABORT: cover property (ce && req.wr && req.addr == 8'haa ##1 ce && req.stop);
	COV_OUTPUT_GATES: cover property (ce && pin_out_en[0] ##1 !pull_up_en[0]);

endmodule

`default_nettype wire

// ==== verif/pdc_pad_config_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module pdc_pad_config_bench;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	pdc_pkg::pdc_req_type req = '0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [pdc_pkg::PIN_COUNT-1:0] pin_out_en = '0;
	logic [pdc_pkg::PIN_COUNT-1:0] pull_up_en;
	logic [pdc_pkg::PIN_COUNT-1:0] pull_down_en;
	logic [pdc_pkg::FIELD_BITS-1:0] drive_level;
	logic [pdc_pkg::FIELD_BITS-1:0] pull_exp = {13{4'ha}};
	logic [pdc_pkg::FIELD_BITS-1:0] drv_exp = '0;
	logic [7:0] adr [8] = '{8'ha0, 8'ha2, 8'ha4, 8'ha6, 8'ha8, 8'haa, 8'hac, 8'hae};
	logic [15:0] val [8] = '{16'he41b, 16'h1be4, 16'hf2d8, 16'h00fd, 16'h00f6, 16'h1b72,
		16'h64d8, 16'h4e93};
	int n_errors = 0;
	int checked = 0;

	always #5 ref_clk = ~ref_clk;

	pdc_pad_config uut (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ce(ce),
		.req(req),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.pin_out_en(pin_out_en),
		.pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en),
		.drive_level(drive_level)
	);

	task automatic cyc();
		@(posedge ref_clk);
		#1;
	endtask

	// Every request is launched 1 ns after an edge and stands for exactly one edge.
	task automatic put(input logic w, input logic r, input logic s, input logic [7:0] a,
		input logic [7:0] d);
		req = {w, r, s, a, d};
		cyc();
	endtask

	function automatic void set_reg(input logic [7:0] a, input logic [15:0] v);
		if (a == 8'ha6)
			drv_exp[48 +: 4] = v[3:0];
		else if (a == 8'ha8)
			pull_exp[48 +: 4] = v[3:0];
		else if (a < 8'ha6)
			drv_exp[8*(a-8'ha0) +: 16] = v;
		else
			pull_exp[8*(a-8'haa) +: 16] = v;
	endfunction

	function automatic logic [7:0] exp_byte(input logic [7:0] a);
		logic [7:0] b;
		b = 8'h00;
		if (a == 8'ha6)
			b = {4'h0, drv_exp[48 +: 4]};
		else if (a == 8'ha8)
			b = {4'h0, pull_exp[48 +: 4]};
		else if (a >= 8'ha0 && a <= 8'ha5)
			b = drv_exp[8*(a-8'ha0) +: 8];
		else if (a >= 8'haa && a <= 8'haf)
			b = pull_exp[8*(a-8'haa) +: 8];
		return b;
	endfunction

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_vec(input string what, input logic [51:0] exp, input logic [51:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_pads();
		logic [25:0] up;
		logic [25:0] dn;
		logic [51:0] lv;
		logic [1:0] s;
		for (int i = 0; i < 26; i++)
		begin
			s = pull_exp[2*i +: 2];
			up[i] = ~pin_out_en[i] & s[1];
			dn[i] = ~pin_out_en[i] & (s == 2'h1);
			s = drv_exp[2*i +: 2];
			lv[2*i +: 2] = (s == 2'h0) ? pdc_pkg::LEVEL_WEAK :
				(s == 2'h3) ? pdc_pkg::LEVEL_STRONG : pdc_pkg::LEVEL_MEDIUM;
		end
		chk_vec("pull_up_en", {26'h0, up}, {26'h0, pull_up_en});
		chk_vec("pull_down_en", {26'h0, dn}, {26'h0, pull_down_en});
		chk_vec("drive_level", lv, drive_level);
	endtask

	task automatic rd_byte(input logic [7:0] a);
		put(1'b0, 1'b1, 1'b0, a, 8'h00);
		chk_byte("reg_rvalid", 8'h01, {7'h0, reg_rvalid});
		chk_byte($sformatf("byte %h", a), exp_byte(a), reg_rdata);
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		put(1'b1, 1'b0, 1'b0, a, v[7:0]);
		if (a != 8'ha6 && a != 8'ha8)
			put(1'b1, 1'b0, 1'b0, a + 8'h01, v[15:8]);
		set_reg(a, v);
	endtask

	task automatic check_all();
		chk_pads();
		for (int a = 'ha0; a <= 'haf; a++)
			rd_byte(8'(a));
		rd_byte(8'h10);
		put(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		chk_byte("reg_rvalid idle", 8'h00, {7'h0, reg_rvalid});
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		check_all();
		$display("test reset values done");
		for (int k = 0; k < 8; k++)
		begin
			wr16(adr[k], val[k]);
			chk_pads();
		end
		check_all();
		$display("test field decode done");
		pin_out_en = 26'h2aaaaaa;
		cyc();
		chk_pads();
		pin_out_en = 26'h1555555;
		cyc();
		chk_pads();
		pin_out_en = '0;
		cyc();
		chk_pads();
		$display("test output gating done");
		// Software keeps every row pin pulled, so no row input is left floating.
		wr16(8'haa, 16'h5555);
		// Low bytes that must be dropped: by stop, by an unmapped write, by another register.
		put(1'b1, 1'b0, 1'b0, 8'haa, 8'h00);
		put(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		put(1'b1, 1'b0, 1'b0, 8'hab, 8'h00);
		put(1'b1, 1'b0, 1'b0, 8'hac, 8'h00);
		put(1'b1, 1'b0, 1'b0, 8'h10, 8'h55);
		put(1'b1, 1'b0, 1'b0, 8'had, 8'h00);
		put(1'b1, 1'b0, 1'b0, 8'hae, 8'h00);
		put(1'b1, 1'b0, 1'b0, 8'ha6, 8'h02);
		set_reg(8'ha6, 16'h0002);
		put(1'b1, 1'b0, 1'b0, 8'haf, 8'h00);
		put(1'b1, 1'b0, 1'b0, 8'ha3, 8'h00);
		ce = 1'b0;
		put(1'b1, 1'b0, 1'b0, 8'ha0, 8'h00);
		put(1'b1, 1'b0, 1'b0, 8'ha1, 8'h00);
		ce = 1'b1;
		put(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		check_all();
		$display("test aborted writes done");
		resetn = 1'b0;
		pull_exp = {13{4'ha}};
		drv_exp = '0;
		cyc();
		chk_pads();
		repeat (4) cyc();
		resetn = 1'b1;
		check_all();
		$display("test second reset done");
		wrap_up();
	end
endmodule

`default_nettype wire
